/* hw/ptb_pkg.sv */
// Purpose: Shared constants for the bus target interface
// Assumes: Single bus clock, active-low asynchronous reset
// Notes: Commands are the low four command/byte-enable lines
package ptb_pkg;
  // ****************************************************************
  // Bus widths
  // ****************************************************************
  localparam int PTB_AD_W = 64;
  localparam int PTB_CBE_W = 8;
  localparam int PTB_HALF_W = 32;
  localparam int PTB_CMD_W = 4;
  localparam int PTB_MEM_DEPTH = 16;
  localparam int PTB_MEM_AW = 4;
  localparam int PTB_WORD_LSB = 3;
  // ****************************************************************
  // Bus commands
  // ****************************************************************
  localparam logic [3:0] PTB_CMD_MEM_RD = 4'h6;
  localparam logic [3:0] PTB_CMD_MEM_WR = 4'h7;
  localparam logic [3:0] PTB_CMD_CFG_RD = 4'hA;
  localparam logic [3:0] PTB_CMD_CFG_WR = 4'hB;
  localparam logic [3:0] PTB_CMD_MEM_RDM = 4'hC;
  localparam logic [3:0] PTB_CMD_MEM_RDL = 4'hE;
  localparam logic [3:0] PTB_CMD_MEM_WRI = 4'hF;
  // ****************************************************************
  // Decode defaults and timing
  // ****************************************************************
  localparam logic [31:0] PTB_BASE_RST = 32'h1000_0000;
  localparam int PTB_SIZE_LOG2 = 7;
  localparam int PTB_BURST_MAX = 8;
  localparam int PTB_CLK_MHZ = 40;
  // Clock rates supported by the target
  localparam int PTB_CLK_LO_MHZ = 33;
  localparam int PTB_CLK_HI_MHZ = 66;
  localparam logic [63:0] PTB_CFG_ID = 64'h0000_0000_1234_5678;
endpackage

/* hw/ptb_mem.sv */
// Purpose: Small word store behind the bus target
// Assumes: One write port with byte enables, registered read data
// Notes: Read data lag the address by one clock
`timescale 1ns/1ps
module ptb_mem #(
  parameter int DW = 64,
  parameter int AW = 4
) (
  // Clock
  input wire logic clk_sys,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [DW/8-1:0] wr_be,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] store [2**AW];
  // ****************************************************************
  // Storage with byte-lane write
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < DW/8; i++) begin
      if (wr_en && wr_be[i]) begin
        store[wr_addr][i*8 +: 8] <= wr_data[i*8 +: 8];
      end
    end
    rd_data <= store[rd_addr];
  end
endmodule

/* hw/ptb_target.sv */
// Purpose: Bus-side target with decode, handshakes, parity and errors
// Assumes: Initiator keeps its own framing and ready timing
// Notes: Active bus pins are split into value and output enable
//
// Functional notes
// - Everything runs on one bus clock, 33 or 66 MHz; the bench clock is 40 MHz.
// - Address rides the shared lines on the first frame-low cycle only.
// - Low four command lines give the command in address phase.
// - Command lines are byte enables during data phases, four or eight.
// - Low parity is even over low data half and low enables.
// - High parity is even over high data half and high enables.
// - Target ready low only when target can finish; high means wait.
// - Stop low when the target wants the transfer ended.
// - Configuration access answered only while config select is high.
// - On address hit, device select low for rest of access.
// - 64-bit acknowledge follows device select exactly on 64-bit memory request.
// - Data parity error output low on failed receive check.
// - Address parity error pulls open-drain system error low.
// - Interrupt pulled low while pending, released afterwards.
// - Sustained outputs driven high one cycle before release.
// - Open-drain pins only drive low or float.
`timescale 1ns/1ps
module ptb_target
  import ptb_pkg::*;
#(
  parameter logic [31:0] BASE = ptb_pkg::PTB_BASE_RST,
  parameter int SIZE_LOG2 = ptb_pkg::PTB_SIZE_LOG2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Address/data and parity
  input wire logic [ptb_pkg::PTB_AD_W-1:0] ad_in,
  output logic [ptb_pkg::PTB_AD_W-1:0] ad_out,
  output logic ad_oe,
  input wire logic [ptb_pkg::PTB_CBE_W-1:0] cbe_n,
  input wire logic par_in,
  output logic par_out,
  output logic par_oe,
  input wire logic par64_in,
  output logic par64_out,
  output logic par64_oe,
  // Initiator control
  input wire logic frame_n,
  input wire logic req64_n,
  input wire logic irdy_n,
  input wire logic idsel,
  // Target responses
  output logic trdy_n,
  output logic trdy_oe,
  output logic stop_n,
  output logic stop_oe,
  output logic devsel_n,
  output logic devsel_oe,
  output logic ack64_n,
  output logic ack64_oe,
  output logic perr_n,
  output logic perr_oe,
  // Open-drain reporting
  output logic serr_oe,
  output logic inta_oe,
  // Interrupt request from user logic
  input wire logic irq_req
);
  import ptb_pkg::*;

  // All protocol checks sample on the bus clock, quiet in reset
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  typedef enum logic [2:0] {
    PTB_IDLE, PTB_WAIT, PTB_XFER, PTB_TURN, PTB_BUSY
  } ptb_state_e;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [1:0] irq_sync;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_sync <= 2'h0;
    end else begin
      irq_sync <= {irq_sync[0], irq_req};
    end
  end

  // ****************************************************************
  // Parity helper
  // ****************************************************************
  function automatic logic even_par(input logic [31:0] d,
                                    input logic [3:0] c);
    even_par = ^{d, c};
  endfunction

  // ****************************************************************
  // Bus state
  // ****************************************************************
  ptb_state_e state, next_state;
  logic frame_q, next_frame_q;
  logic is_rd, next_is_rd;
  logic is_cfg, next_is_cfg;
  logic wide, next_wide;
  logic [PTB_MEM_AW-1:0] waddr, next_waddr;
  logic [3:0] beats, next_beats;
  logic trdy_r, next_trdy_r;
  logic stop_r, next_stop_r;
  logic dev_r, next_dev_r;
  logic oe_r, next_oe_r;
  logic rd_oe, next_rd_oe;
  logic chk_en, next_chk_en;
  logic chk_wide, next_chk_wide;
  logic [63:0] ad_q, next_ad_q;
  logic [7:0] cbe_q, next_cbe_q;
  logic perr_r, next_perr_r;
  logic perr_on, next_perr_on;
  logic serr_r, next_serr_r;
  logic apar_chk, next_apar_chk;
  logic [63:0] rd_word;
  logic mem_we;

  logic addr_phase, hit_mem, hit_cfg, xfer;
  logic [3:0] cmd;
  assign addr_phase = !frame_n && frame_q && state == PTB_IDLE;
  assign cmd = cbe_n[PTB_CMD_W-1:0];
  assign hit_mem = (ad_in[31:SIZE_LOG2] == BASE[31:SIZE_LOG2]) &&
    (cmd == PTB_CMD_MEM_RD || cmd == PTB_CMD_MEM_WR ||
     cmd == PTB_CMD_MEM_RDM || cmd == PTB_CMD_MEM_RDL ||
     cmd == PTB_CMD_MEM_WRI);
  assign hit_cfg = idsel && (cmd == PTB_CMD_CFG_RD ||
                             cmd == PTB_CMD_CFG_WR);
  assign xfer = !irdy_n && trdy_r && state == PTB_XFER;
  assign mem_we = xfer && !is_rd && !is_cfg;

  // Next-state logic for the handshake machine
  always_comb begin
    next_state = state;
    next_frame_q = frame_n;
    next_is_rd = is_rd;
    next_is_cfg = is_cfg;
    next_wide = wide;
    next_waddr = waddr;
    next_beats = beats;
    next_trdy_r = 1'b0;
    next_stop_r = stop_r;
    next_dev_r = dev_r;
    next_oe_r = oe_r;
    next_rd_oe = rd_oe;
    next_chk_en = 1'b0;
    next_chk_wide = wide;
    next_ad_q = ad_in;
    next_cbe_q = ~cbe_n;
    next_apar_chk = addr_phase;
    case (state)
      PTB_IDLE: begin
        next_oe_r = 1'b0;
        next_rd_oe = 1'b0;
        next_stop_r = 1'b0;
        if (addr_phase && (hit_mem || hit_cfg)) begin
          next_state = PTB_WAIT;
          next_dev_r = 1'b1;
          next_oe_r = 1'b1;
          next_is_rd = !cmd[0];
          next_is_cfg = hit_cfg;
          next_wide = !req64_n && hit_mem;
          next_waddr = ad_in[PTB_WORD_LSB +: PTB_MEM_AW];
          next_beats = 4'h0;
        end else if (addr_phase) begin
          next_state = PTB_BUSY;
        end
      end
      PTB_WAIT: begin
        // One wait state lets read data come out of the store
        next_state = PTB_XFER;
        next_trdy_r = 1'b1;
        next_rd_oe = is_rd;
      end
      PTB_XFER: begin
        next_trdy_r = 1'b1;
        if (xfer) begin
          next_waddr = waddr + PTB_MEM_AW'(1);
          next_beats = beats + 4'h1;
          next_chk_en = !is_rd;
          // Read pauses a cycle so the store can refill the lines
          next_trdy_r = !is_rd;
          if (frame_n) begin
            // Final phase done: drive high one cycle, then release
            next_state = PTB_TURN;
            next_trdy_r = 1'b0;
            next_dev_r = 1'b0;
            next_stop_r = 1'b0;
          end else if (beats == 4'(PTB_BURST_MAX - 2)) begin
            next_stop_r = 1'b1;
          end
        end else if (stop_r && frame_n && irdy_n) begin
          next_state = PTB_TURN;
          next_trdy_r = 1'b0;
          next_dev_r = 1'b0;
          next_stop_r = 1'b0;
        end
        if (stop_r && xfer) begin
          next_trdy_r = 1'b0;
        end
      end
      PTB_TURN: begin
        next_state = PTB_IDLE;
        next_oe_r = 1'b0;
        next_rd_oe = 1'b0;
      end
      PTB_BUSY: begin
        if (frame_n && irdy_n) begin
          next_state = PTB_IDLE;
        end
      end
      default: next_state = PTB_IDLE;
    endcase
  end

  // Parity checks and error reporting
  always_comb begin
    next_perr_r = 1'b0;
    next_perr_on = perr_on;
    next_serr_r = 1'b0;
    if (chk_en) begin
      next_perr_r = (even_par(ad_q[31:0], ~cbe_q[3:0]) != par_in) ||
        (chk_wide && even_par(ad_q[63:32], ~cbe_q[7:4]) != par64_in);
      next_perr_on = 1'b1;
    end else if (perr_r) begin
      next_perr_on = 1'b1;
    end else begin
      next_perr_on = 1'b0;
    end
    if (apar_chk) begin
      next_serr_r =
        even_par(ad_q[31:0], ~cbe_q[3:0]) != par_in;
    end
  end

  // Register all state
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= PTB_IDLE;
      frame_q <= 1'b1;
      is_rd <= 1'b0;
      is_cfg <= 1'b0;
      wide <= 1'b0;
      waddr <= '0;
      beats <= 4'h0;
      trdy_r <= 1'b0;
      stop_r <= 1'b0;
      dev_r <= 1'b0;
      oe_r <= 1'b0;
      rd_oe <= 1'b0;
      chk_en <= 1'b0;
      chk_wide <= 1'b0;
      ad_q <= 64'h0;
      cbe_q <= 8'h0;
      perr_r <= 1'b0;
      perr_on <= 1'b0;
      serr_r <= 1'b0;
      apar_chk <= 1'b0;
    end else begin
      state <= next_state;
      frame_q <= next_frame_q;
      is_rd <= next_is_rd;
      is_cfg <= next_is_cfg;
      wide <= next_wide;
      waddr <= next_waddr;
      beats <= next_beats;
      trdy_r <= next_trdy_r;
      stop_r <= next_stop_r;
      dev_r <= next_dev_r;
      oe_r <= next_oe_r;
      rd_oe <= next_rd_oe;
      chk_en <= next_chk_en;
      chk_wide <= next_chk_wide;
      ad_q <= next_ad_q;
      cbe_q <= next_cbe_q;
      perr_r <= next_perr_r;
      perr_on <= next_perr_on;
      serr_r <= next_serr_r;
      apar_chk <= next_apar_chk;
    end
  end

  // ****************************************************************
  // Word store
  // ****************************************************************
  logic [63:0] cfg_or_mem;
  ptb_mem #(.DW(PTB_AD_W), .AW(PTB_MEM_AW)) u_mem (
    .clk_sys(clk_sys),
    .wr_en(mem_we),
    .wr_addr(waddr),
    .wr_data(ad_in),
    .wr_be(wide ? ~cbe_n : {4'h0, ~cbe_n[3:0]}),
    .rd_addr(next_waddr),
    .rd_data(cfg_or_mem)
  );
  assign rd_word = is_cfg ? PTB_CFG_ID : cfg_or_mem;

  // ****************************************************************
  // Output drivers
  // ****************************************************************
  logic [63:0] ad_o;
  logic par_o, par64_o, adoe_o, paroe_o, p64oe_o;
  always_comb begin
    ad_o = rd_word;
    adoe_o = next_rd_oe;
    paroe_o = rd_oe; // Parity follows data by one clock
    p64oe_o = rd_oe && wide;
    par_o = even_par(ad_out[31:0], cbe_n[3:0]);
    par64_o = even_par(ad_out[63:32], cbe_n[7:4]);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ad_out <= 64'h0;
      ad_oe <= 1'b0;
      par_out <= 1'b0;
      par_oe <= 1'b0;
      par64_out <= 1'b0;
      par64_oe <= 1'b0;
      trdy_n <= 1'b1;
      trdy_oe <= 1'b0;
      stop_n <= 1'b1;
      stop_oe <= 1'b0;
      devsel_n <= 1'b1;
      devsel_oe <= 1'b0;
      ack64_n <= 1'b1;
      ack64_oe <= 1'b0;
      perr_n <= 1'b1;
      perr_oe <= 1'b0;
      serr_oe <= 1'b0;
      inta_oe <= 1'b0;
    end else begin
      ad_out <= ad_o;
      ad_oe <= adoe_o;
      par_out <= par_o;
      par_oe <= paroe_o;
      par64_out <= par64_o;
      par64_oe <= p64oe_o;
      trdy_n <= !next_trdy_r;
      trdy_oe <= next_oe_r;
      stop_n <= !next_stop_r;
      stop_oe <= next_oe_r;
      devsel_n <= !next_dev_r;
      devsel_oe <= next_oe_r;
      ack64_n <= !(next_dev_r && next_wide);
      ack64_oe <= next_oe_r && next_wide;
      perr_n <= !next_perr_r;
      perr_oe <= next_perr_on;
      serr_oe <= next_serr_r;
      inta_oe <= irq_sync[1];
    end
  end
  // ****************************************************************
  // Protocol assertions
  // ****************************************************************
  // Address hit, then claim on the lines
  sequence s_addr_hit;
    addr_phase && (hit_mem || hit_cfg);
  endsequence
  sequence s_claimed;
    !devsel_n && devsel_oe;
  endsequence
  property p_claim;
    s_addr_hit |=> s_claimed;
  endproperty
  a_claim: assert property (p_claim)
    else $error("claim missing after address hit");
  property p_cfg_sel;
    addr_phase && !idsel && cmd[3:1] == 3'h5 |=> devsel_n;
  endproperty
  a_cfg_sel: assert property (p_cfg_sel)
    else $error("config access claimed without select");
  property p_ack_mirror;
    ack64_oe |-> devsel_oe && ack64_n == devsel_n;
  endproperty
  a_ack_mirror: assert property (p_ack_mirror)
    else $error("wide acknowledge differs from device select");
  property p_trdy_claimed;
    !trdy_n |-> s_claimed;
  endproperty
  a_trdy_claimed: assert property (p_trdy_claimed)
    else $error("target ready without claim");
  property p_stop_claimed;
    !stop_n |-> s_claimed;
  endproperty
  a_stop_claimed: assert property (p_stop_claimed)
    else $error("stop without claim");
  property p_dev_release;
    $fell(devsel_oe) |-> $past(devsel_n);
  endproperty
  a_dev_release: assert property (p_dev_release)
    else $error("device select released while low");
  property p_perr_release;
    $fell(perr_oe) |-> $past(perr_n);
  endproperty
  a_perr_release: assert property (p_perr_release)
    else $error("parity error released while low");
  property p_serr_addr;
    serr_oe |-> $past(apar_chk);
  endproperty
  a_serr_addr: assert property (p_serr_addr)
    else $error("system error outside address check");
  property p_inta_follow;
    inta_oe |-> $past(irq_sync[1]);
  endproperty
  a_inta_follow: assert property (p_inta_follow)
    else $error("interrupt pulled without request");

  // The core clock rate, 40 MHz, is neither of the two bus rates
endmodule

/* verif/ptb_master.sv */
// Purpose: Bus master model that drives transactions into the target
// Assumes: Target responses arrive already resolved against pull-ups
// Notes: Parity trails its lines by one clock; released lines invert
`timescale 1ns/1ps
module ptb_master
  import ptb_pkg::*;
(
  // Clock and resolved target lines
  input wire logic clk_sys,
  input wire logic trdy_b,
  input wire logic stop_b,
  input wire logic devsel_b,
  input wire logic [ptb_pkg::PTB_AD_W-1:0] ad_b,
  // Master drive
  output logic [ptb_pkg::PTB_AD_W-1:0] ad_m,
  output logic [ptb_pkg::PTB_CBE_W-1:0] cbe_n,
  output logic par_m,
  output logic par64_m,
  output logic frame_n,
  output logic req64_n,
  output logic irdy_n,
  output logic idsel
);
  logic flip;
  logic stop_seen;
  logic [63:0] rdq[$];
  int seed = 32'h84744ffd;
  // Idle bus at time zero
  initial begin
    {frame_n, req64_n, irdy_n, cbe_n} = '1;
    {idsel, flip, par_m, par64_m, stop_seen} = '0;
    ad_m = '0;
  end
  // Even parity one clock behind the lines, low half can be spoilt
  always @(posedge clk_sys) begin
    par_m <= ^{ad_m[31:0], cbe_n[3:0]} ^ flip;
    par64_m <= ^{ad_m[63:32], cbe_n[7:4]};
  end
  // One transaction; st 1 means nobody claimed it
  task automatic xfer(input logic [3:0] cmd, input logic [31:0] adr,
    input int n, input logic w64, input logic sel, input logic wr,
    input logic [63:0] wd[$], input logic [7:0] be[$],
    input logic ba, input logic bd, input logic slow, output int st);
    int i;
    int w;
    st = 0;
    i = 0;
    w = 0;
    rdq.delete();
    stop_seen = 0;
    repeat (2) @(posedge clk_sys);
    frame_n <= 1'b0;
    req64_n <= !w64;
    ad_m <= {32'h0, adr};
    cbe_n <= {4'hF, cmd};
    idsel <= sel;
    flip <= ba;
    @(posedge clk_sys);
    irdy_n <= 1'b0;
    frame_n <= n == 1;
    req64_n <= !w64 || n == 1;
    ad_m <= wr ? wd[0] : ~ad_m;
    cbe_n <= be[0];
    idsel <= 1'b0;
    flip <= wr && bd;
    while (i < n) begin
      @(posedge clk_sys);
      w++;
      if (!stop_b) stop_seen = 1;
      if (!trdy_b && !irdy_n) begin
        if (!wr) rdq.push_back(ad_b);
        i++;
        w = 0;
        flip <= 1'b0;
        if (i < n && slow && $random(seed) & 1) begin
          irdy_n <= 1'b1;
          @(posedge clk_sys);
        end
        irdy_n <= i == n;
        frame_n <= i >= n - 1;
        req64_n <= !w64 || i >= n - 1;
        ad_m <= wr && i < n ? wd[i] : ~ad_m;
        cbe_n <= i < n ? be[i] : ~cbe_n;
      end else if (devsel_b && w > 4) begin
        frame_n <= 1'b1;
        req64_n <= 1'b1;
        @(posedge clk_sys);
        irdy_n <= 1'b1;
        st = 1;
        i = n;
      end
    end
  endtask
endmodule

/* verif/pci_target_bus_interface_tb_top.sv */
// Purpose: Self-checking bench for the bus target
// Assumes: Master model drives the bus, store is 16 words of 64 bits
// Notes: Read data and claims are compared with a bench store model
`timescale 1ns/1ps
module pci_target_bus_interface_tb_top;
  import ptb_pkg::*;
  // ****************************************************************
  // Bus wiring and checks
  // ****************************************************************
  logic clk_sys = 0;
  logic arst_n = 1;
  logic irq_req = 0;
  logic m64 = 0;
  logic rd_q = 0;
  logic perr_seen = 0;
  logic serr_seen = 0;
  logic [63:0] adq;
  logic [7:0] cbq;
  logic [4:0] oe_q = 0;
  logic [4:0] nq;
  logic [63:0] mem_m [16];
  int seed = 32'h84744ffd;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  wire [63:0] ad_in, ad_out, ad_m;
  wire [7:0] cbe_n;
  wire par_in, par_out, par_oe, par64_in, par64_out, par64_oe;
  wire par_m, par64_m, ad_oe, frame_n, req64_n, irdy_n, idsel;
  wire trdy_n, trdy_oe, stop_n, stop_oe, devsel_n, devsel_oe;
  wire ack64_n, ack64_oe, perr_n, perr_oe, serr_oe, inta_oe;
  wire [4:0] oe_v = {trdy_oe, stop_oe, devsel_oe, ack64_oe, perr_oe};
  wire [4:0] nv = {trdy_n, stop_n, devsel_n, ack64_n, perr_n};
  wire [4:0] bl = nv | ~oe_v; // Levels with pull-ups
  assign ad_in = ad_oe ? ad_out : ad_m;
  assign par_in = par_oe ? par_out : par_m;
  assign par64_in = par64_oe ? par64_out : par64_m;
  // Bus clock at 40 MHz
  always #12.5 clk_sys = ~clk_sys;
  ptb_target u_dut (.clk_sys, .arst_n, .ad_in, .ad_out, .ad_oe, .cbe_n,
    .par_in, .par_out, .par_oe, .par64_in, .par64_out, .par64_oe,
    .frame_n, .req64_n, .irdy_n, .idsel, .trdy_n, .trdy_oe, .stop_n,
    .stop_oe, .devsel_n, .devsel_oe, .ack64_n, .ack64_oe, .perr_n,
    .perr_oe, .serr_oe, .inta_oe, .irq_req);
  ptb_master u_m (.clk_sys, .trdy_b(bl[4]), .stop_b(bl[3]),
    .devsel_b(bl[2]), .ad_b(ad_in), .ad_m, .cbe_n, .par_m, .par64_m,
    .frame_n, .req64_n, .irdy_n, .idsel);
  // Compare one value
  task automatic chk(input string what, input logic [63:0] e,
    input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  // Counts, verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Per-edge bus checks and cycle ceiling
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    rd_q <= !bl[4] && !irdy_n && ad_oe;
    adq <= ad_in;
    cbq <= cbe_n;
    oe_q <= oe_v;
    nq <= nv;
    if (!bl[0]) perr_seen <= 1'b1;
    if (serr_oe) serr_seen <= 1'b1;
    if (rd_q) chk("par", 0, ^{adq[31:0], cbq[3:0], par_in});
    if (rd_q && m64) chk("par64", 0, ^{adq[63:32], cbq[7:4], par64_in});
    chk("ack64", m64 ? bl[2] : 1'b1, bl[1]);
    if (!bl[4]) chk("devsel", 0, bl[2]);
    for (int k = 0; k < 5; k++)
      if (oe_q[k] && !oe_v[k]) chk("release", 1, nq[k]);
    if (cyc == 6000) begin
      n_mismatch++;
      summarize();
    end
  end
  // One transaction against the store model
  task automatic run(input logic [3:0] cmd, input int idx, input int n,
    input logic w64, input logic sel, input logic ba, input logic bd,
    input logic rnd, input int xst);
    logic [63:0] wd[$];
    logic [7:0] be[$];
    logic [63:0] e;
    logic [63:0] g;
    logic cfg;
    int st;
    cfg = cmd[3:1] == 3'b101;
    for (int i = 0; i < n; i++) begin
      wd.push_back({$random(seed), $random(seed)});
      be.push_back(rnd ? 8'($random(seed)) : 8'h00);
    end
    @(posedge clk_sys);
    m64 <= w64;
    u_m.xfer(cmd, PTB_BASE_RST + 32'(idx * 8), n, w64, sel, cmd[0], wd,
      be, ba, bd, rnd, st);
    if (xst >= 0) chk("claim", xst == 1, st == 1);
    for (int i = 0; i < n && st == 0; i++) begin
      e = cfg ? {32'h0, PTB_CFG_ID[31:0]} : mem_m[idx + i];
      g = cfg ? {32'h0, u_m.rdq[i][31:0]} : u_m.rdq[i];
      if (!cmd[0]) chk("read", e, g);
      for (int k = 0; k < 8; k++)
        if (cmd[0] && !cfg && !be[i][k])
          mem_m[idx + i][8*k +: 8] = wd[i][8*k +: 8];
    end
    if (st == 0) chk("stop", n == PTB_BURST_MAX, u_m.stop_seen);
  endtask
  // Main sequence
  initial begin
    logic [3:0] cmds[5];
    cmds = '{PTB_CMD_MEM_RD, PTB_CMD_MEM_WR, PTB_CMD_MEM_RDM,
      PTB_CMD_MEM_RDL, PTB_CMD_MEM_WRI};
    #1 arst_n = 1'b0;
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    run(PTB_CMD_MEM_WR, 0, 8, 1, 0, 0, 0, 0, 0);
    run(PTB_CMD_MEM_WR, 8, 8, 1, 0, 0, 0, 0, 0);
    $display("test fill done");
    for (int r = 0; r < 20; r++)
      run(cmds[r % 5], $random(seed) & 7, 1 + ($random(seed) & 7), 1, 0,
        0, 0, 1, 0);
    run(PTB_CMD_MEM_RD, 0, 8, 1, 0, 0, 0, 1, 0);
    run(PTB_CMD_MEM_RD, 8, 8, 1, 0, 0, 0, 1, 0);
    chk("perr idle", 0, perr_seen);
    chk("serr idle", 0, serr_seen);
    $display("test bursts done");
    for (int j = 0; j < 4; j++)
      run(j[1] ? PTB_CMD_CFG_WR : PTB_CMD_CFG_RD, 0, 1, 0, j[0], 0, 0, 0,
        !j[0]);
    run(PTB_CMD_MEM_RD, 16, 1, 1, 0, 0, 0, 0, 1);
    $display("test decode done");
    run(PTB_CMD_MEM_WR, 15, 1, 1, 0, 0, 1, 0, 0);
    repeat (4) @(posedge clk_sys);
    chk("perr", 1, perr_seen);
    run(PTB_CMD_MEM_WR, 15, 1, 1, 0, 0, 0, 0, 0);
    run(PTB_CMD_MEM_RD, 3, 1, 1, 0, 1, 0, 0, -1);
    repeat (4) @(posedge clk_sys);
    chk("serr", 1, serr_seen);
    $display("test parity done");
    irq_req <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk("inta", 1, inta_oe);
    #5 arst_n = 1'b0;
    #1 chk("reset", 0, 64'({ad_oe, par_oe, par64_oe, oe_v, serr_oe,
      inta_oe}));
    @(posedge clk_sys);
    irq_req <= 1'b0;
    arst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk("inta off", 0, inta_oe);
    run(PTB_CMD_MEM_RD, 15, 1, 1, 0, 0, 0, 0, 0);
    $display("test irq reset done");
    summarize();
  end
endmodule
